// ---- rtl/digital_loop_core_core.sv ----
// Digital loop core: dividers, detector, filter, estimator, holdover
`timescale 1ns/10ps
`default_nettype none
`include "digital_loop_core_defs.svh"
module digital_loop_core_core
   import digital_loop_core_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         first_reference_input,
   input  wire logic         second_reference_input,
   input  wire logic         feedback_input,
   output logic [31:0]       tuning_word,
   input  wire logic         reference_choice_pin_in,
   output logic              reference_choice_pin_out,
   output logic              reference_choice_pin_oe_n,
   input  wire logic         holdover_pin_in,
   output logic              holdover_pin_out,
   output logic              holdover_pin_oe_n,
   output logic              irq,
   input  wire logic [7:0]   s_axi_awaddr,
   input  wire logic         s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   input  wire logic         s_axi_wvalid,
   output logic              s_axi_wready,
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire logic         s_axi_bready,
   input  wire logic [7:0]   s_axi_araddr,
   input  wire logic         s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire logic         s_axi_rready
);

   localparam logic [11:0] LOSS_LIM = 12'(`DIGITAL_LOOP_CORE_LOSS_CYC);

   digital_loop_core_core_t r;
   digital_loop_core_core_t next_r;

   digital_loop_core_div_if ref_a_if ();
   digital_loop_core_div_if ref_b_if ();
   digital_loop_core_div_if fb_if ();

   logic        lost_a;
   logic        lost_b;
   logic        act_lost;
   logic        oth_lost;
   logic        act_div;
   logic        hold_req;
   logic        pfd_done;
   logic        sw_ev;
   logic [3:0]  ev;
   logic [3:0]  clr;
   logic [31:0] err;
   logic [31:0] integ_n;
   logic [31:0] ftw_n;
   logic [32:0] rem2;
   logic [31:0] wm;
   logic [7:0]  ra;

   function automatic logic [31:0] wmerge(input logic [31:0] o,
                                          input logic [31:0] d,
                                          input logic [3:0]  st);
      logic [31:0] m;
      m = o;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            m[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return m;
   endfunction

   function automatic logic [31:0] shl(input logic [31:0] e,
                                       input logic [3:0]  sh);
      return e << sh;
   endfunction

   function automatic logic [11:0] loss_step(input logic [11:0] c,
                                             input logic        t);
      if (t) begin
         return 12'h000;
      end else if (c == LOSS_LIM) begin
         return c;
      end
      return c + 12'h001;
   endfunction

   assign ref_a_if.ratio = r.rdiv;
   assign ref_b_if.ratio = r.rdiv;
   assign fb_if.ratio = r.sdiv;

   digital_loop_core_divider u_div_a (
      .clk  (clk),
      .nrst (nrst),
      .pin  (first_reference_input),
      .port (ref_a_if)
   );
   digital_loop_core_divider u_div_b (
      .clk  (clk),
      .nrst (nrst),
      .pin  (second_reference_input),
      .port (ref_b_if)
   );
   digital_loop_core_divider u_div_fb (
      .clk  (clk),
      .nrst (nrst),
      .pin  (feedback_input),
      .port (fb_if)
   );

   always_comb begin
      next_r = r;
      pfd_done = 1'b0;
      sw_ev = 1'b0;
      ev = 4'h0;
      clr = 4'h0;
      err = 32'h0000_0000;
      integ_n = r.integ;
      ftw_n = r.ftw;
      rem2 = 33'h0_0000_0000;
      wm = 32'h0000_0000;
      ra = {s_axi_araddr[7:2], 2'h0};
      // Pin synchronisers
      next_r.hold_s1 = holdover_pin_in;
      next_r.hold_s2 = r.hold_s1;
      next_r.sel_s1 = reference_choice_pin_in;
      next_r.sel_s2 = r.sel_s1;
      // Reference monitors
      next_r.loss_a = loss_step(r.loss_a, ref_a_if.tick);
      next_r.loss_b = loss_step(r.loss_b, ref_b_if.tick);
      lost_a = r.loss_a == LOSS_LIM;
      lost_b = r.loss_b == LOSS_LIM;
      act_lost = r.sel ? lost_b : lost_a;
      oth_lost = r.sel ? lost_a : lost_b;
      if ((next_r.loss_a == LOSS_LIM && !lost_a) ||
          (next_r.loss_b == LOSS_LIM && !lost_b)) begin
         ev[`DIGITAL_LOOP_CORE_I_LOSS] = 1'b1;
      end
      // Reference choice
      if (r.ctrl[`DIGITAL_LOOP_CORE_C_SWA]) begin
         if (act_lost && !oth_lost) begin
            next_r.sel = ~r.sel;
            sw_ev = 1'b1;
         end
      end else if (r.sel_s2 != r.sel) begin
         next_r.sel = r.sel_s2;
         sw_ev = 1'b1;
      end
      ev[`DIGITAL_LOOP_CORE_I_SW] = sw_ev;
      act_div = r.sel ? ref_b_if.div_tick : ref_a_if.div_tick;
      // Three-state detector
      if (sw_ev) begin
         next_r.pfd_up = 1'b0;
         next_r.pfd_dn = 1'b0;
      end else if (act_div && fb_if.div_tick) begin
         pfd_done = 1'b1;
         next_r.pfd_up = 1'b0;
         next_r.pfd_dn = 1'b0;
      end else if (act_div) begin
         if (r.pfd_dn) begin
            pfd_done = 1'b1;
            err = 32'h0 - 32'({12'h000, r.pfd_cnt});
            next_r.pfd_dn = 1'b0;
         end else if (!r.pfd_up) begin
            next_r.pfd_up = 1'b1;
            next_r.pfd_cnt = 20'h00000;
         end
      end else if (fb_if.div_tick) begin
         if (r.pfd_up) begin
            pfd_done = 1'b1;
            err = 32'({12'h000, r.pfd_cnt});
            next_r.pfd_up = 1'b0;
         end else if (!r.pfd_dn) begin
            next_r.pfd_dn = 1'b1;
            next_r.pfd_cnt = 20'h00000;
         end
      end
      if ((r.pfd_up || r.pfd_dn) && r.pfd_cnt != 20'hfffff &&
          next_r.pfd_cnt == r.pfd_cnt) begin
         next_r.pfd_cnt = r.pfd_cnt + 20'h00001;
      end
      // Holdover request
      if (r.ctrl[`DIGITAL_LOOP_CORE_C_HOLDA]) begin
         hold_req = act_lost;
      end else begin
         hold_req = r.hold_s2;
      end
      // Acquisition and loop control
      case (r.st)
         ST_IDLE: begin
            next_r.ftw = r.ftwi;
            if (r.ctrl[`DIGITAL_LOOP_CORE_C_RUN]) begin
               if (r.ctrl[`DIGITAL_LOOP_CORE_C_EST]) begin
                  next_r.st = ST_MEAS;
                  next_r.meas_arm = 1'b0;
               end else begin
                  next_r.base = r.ftwi;
                  next_r.integ = 32'h0000_0000;
                  next_r.avg = r.ftwi;
                  next_r.st = ST_LOCK;
                  ev[`DIGITAL_LOOP_CORE_I_LOCK] = 1'b1;
               end
            end
         end
         ST_MEAS: begin
            if (act_div) begin
               if (!r.meas_arm) begin
                  next_r.meas_arm = 1'b1;
                  next_r.meas_cnt = 32'h0000_0000;
               end else begin
                  next_r.meas_cnt = r.meas_cnt + 32'h0000_0001;
                  next_r.div_rem = {16'h0000, 17'(r.sdiv) + 17'h00001};
                  next_r.div_q = 32'h0000_0000;
                  next_r.div_i = 6'h00;
                  next_r.st = ST_DIV;
               end
            end else if (r.meas_arm) begin
               next_r.meas_cnt = r.meas_cnt + 32'h0000_0001;
            end
         end
         ST_DIV: begin
            if (r.div_i == 6'h00) begin
               next_r.div_ovf = r.div_rem >= {1'b0, r.meas_cnt};
            end
            if (r.div_i == 6'h20) begin
               ftw_n = r.div_ovf ? `DIGITAL_LOOP_CORE_FTW_SAT : r.div_q;
               next_r.base = ftw_n;
               next_r.ftw = ftw_n;
               next_r.integ = 32'h0000_0000;
               next_r.avg = ftw_n;
               next_r.pfd_up = 1'b0;
               next_r.pfd_dn = 1'b0;
               next_r.st = ST_LOCK;
               ev[`DIGITAL_LOOP_CORE_I_LOCK] = 1'b1;
            end else begin
               rem2 = {r.div_rem[31:0], 1'b0};
               if (rem2 >= {1'b0, r.meas_cnt}) begin
                  next_r.div_rem = rem2 - {1'b0, r.meas_cnt};
                  next_r.div_q = {r.div_q[30:0], 1'b1};
               end else begin
                  next_r.div_rem = rem2;
                  next_r.div_q = {r.div_q[30:0], 1'b0};
               end
               next_r.div_i = r.div_i + 6'h01;
            end
         end
         ST_LOCK: begin
            if (hold_req) begin
               next_r.ftw = r.avg;
               next_r.st = ST_HOLD;
               ev[`DIGITAL_LOOP_CORE_I_HOLD] = 1'b1;
            end else if (pfd_done) begin
               integ_n = r.integ + shl(err, r.gain[7:4]);
               ftw_n = r.base + integ_n + shl(err, r.gain[3:0]);
               next_r.integ = integ_n;
               next_r.ftw = ftw_n;
               next_r.avg = r.avg +
                  32'($signed(ftw_n - r.avg) >>> `DIGITAL_LOOP_CORE_AVG_SH);
            end
         end
         ST_HOLD: begin
            next_r.ftw = r.avg;
            if (!hold_req) begin
               next_r.st = ST_LOCK;
               next_r.pfd_up = 1'b0;
               next_r.pfd_dn = 1'b0;
            end
         end
         default: begin
            next_r.st = ST_IDLE;
         end
      endcase
      if (!r.ctrl[`DIGITAL_LOOP_CORE_C_RUN]) begin
         next_r.st = ST_IDLE;
      end
      // Register bus: write side
      if (r.bvalid && s_axi_bready) begin
         next_r.bvalid = 1'b0;
      end
      if (s_axi_awvalid && r.awready) begin
         next_r.aw_got = 1'b1;
         next_r.awaddr = {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && r.wready) begin
         next_r.w_got = 1'b1;
         next_r.wdata = s_axi_wdata;
         next_r.wstrb = s_axi_wstrb;
      end
      if (r.aw_got && r.w_got && !r.bvalid) begin
         next_r.aw_got = 1'b0;
         next_r.w_got = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = `DIGITAL_LOOP_CORE_OKAY;
         case (r.awaddr)
            `DIGITAL_LOOP_CORE_A_CTRL: begin
               wm = wmerge({27'h0, 1'b0, r.ctrl}, r.wdata, r.wstrb);
               next_r.ctrl = wm[3:0];
               if (wm[`DIGITAL_LOOP_CORE_C_RESTART]) begin
                  next_r.st = ST_IDLE;
               end
            end
            `DIGITAL_LOOP_CORE_A_RDIV: begin
               wm = wmerge({16'h0, r.rdiv}, r.wdata, r.wstrb);
               next_r.rdiv = wm[15:0];
            end
            `DIGITAL_LOOP_CORE_A_SDIV: begin
               wm = wmerge({16'h0, r.sdiv}, r.wdata, r.wstrb);
               next_r.sdiv = wm[15:0];
            end
            `DIGITAL_LOOP_CORE_A_GAIN: begin
               wm = wmerge({24'h0, r.gain}, r.wdata, r.wstrb);
               next_r.gain = wm[7:0];
            end
            `DIGITAL_LOOP_CORE_A_FTWI: begin
               next_r.ftwi = wmerge(r.ftwi, r.wdata, r.wstrb);
            end
            `DIGITAL_LOOP_CORE_A_ICLR: begin
               wm = wmerge(32'h0, r.wdata, r.wstrb);
               clr = wm[3:0];
            end
            `DIGITAL_LOOP_CORE_A_IEN: begin
               wm = wmerge({28'h0, r.ien}, r.wdata, r.wstrb);
               next_r.ien = wm[3:0];
            end
            `DIGITAL_LOOP_CORE_A_STAT, `DIGITAL_LOOP_CORE_A_FTW, `DIGITAL_LOOP_CORE_A_ISTAT: begin
               next_r.bresp = `DIGITAL_LOOP_CORE_OKAY;
            end
            default: begin
               next_r.bresp = `DIGITAL_LOOP_CORE_SLVERR;
            end
         endcase
      end
      next_r.awready = ~next_r.aw_got;
      next_r.wready = ~next_r.w_got;
      // Register bus: read side
      if (r.rvalid && s_axi_rready) begin
         next_r.rvalid = 1'b0;
      end
      if (s_axi_arvalid && r.arready) begin
         next_r.rvalid = 1'b1;
         next_r.rresp = `DIGITAL_LOOP_CORE_OKAY;
         case (ra)
            `DIGITAL_LOOP_CORE_A_CTRL:  next_r.rdata = {28'h0, r.ctrl};
            `DIGITAL_LOOP_CORE_A_RDIV:  next_r.rdata = {16'h0, r.rdiv};
            `DIGITAL_LOOP_CORE_A_SDIV:  next_r.rdata = {16'h0, r.sdiv};
            `DIGITAL_LOOP_CORE_A_GAIN:  next_r.rdata = {24'h0, r.gain};
            `DIGITAL_LOOP_CORE_A_FTWI:  next_r.rdata = r.ftwi;
            `DIGITAL_LOOP_CORE_A_STAT:  next_r.rdata =
               32'({lost_b, lost_a, r.hold_out, r.sel, r.st});
            `DIGITAL_LOOP_CORE_A_FTW:   next_r.rdata = r.ftw;
            `DIGITAL_LOOP_CORE_A_ISTAT: next_r.rdata = {28'h0, r.istat};
            `DIGITAL_LOOP_CORE_A_ICLR:  next_r.rdata = 32'h0000_0000;
            `DIGITAL_LOOP_CORE_A_IEN:   next_r.rdata = {28'h0, r.ien};
            default: begin
               next_r.rdata = 32'h0000_0000;
               next_r.rresp = `DIGITAL_LOOP_CORE_SLVERR;
            end
         endcase
      end
      next_r.arready = ~next_r.rvalid;
      // Interrupts: a new event wins over a clear
      next_r.istat = (r.istat & ~clr) | ev;
      next_r.irq = |(next_r.istat & next_r.ien);
      // Two-way pins
      next_r.sel_oe_n = ~r.ctrl[`DIGITAL_LOOP_CORE_C_SWA];
      next_r.hold_oe_n = ~r.ctrl[`DIGITAL_LOOP_CORE_C_HOLDA];
      next_r.hold_out = r.st == ST_HOLD;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
         r.gain <= `DIGITAL_LOOP_CORE_RST_GAIN;
         r.ftwi <= `DIGITAL_LOOP_CORE_RST_FTWI;
         r.sel_oe_n <= 1'b1;
         r.hold_oe_n <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign tuning_word = r.ftw;
   assign reference_choice_pin_out = r.sel;
   assign reference_choice_pin_oe_n = r.sel_oe_n;
   assign holdover_pin_out = r.hold_out;
   assign holdover_pin_oe_n = r.hold_oe_n;
   assign irq = r.irq;
   assign s_axi_awready = r.awready;
   assign s_axi_wready = r.wready;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = r.arready;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rresp = r.rresp;
   assign s_axi_rdata = r.rdata;

   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   hold_word_a: assert property (r.st == ST_HOLD |=> tuning_word == $past(r.avg))
      else $error("holdover word is not the average");
   meas_quiet_a: assert property (r.st == ST_MEAS |=> $stable(tuning_word))
      else $error("tuning word moved during measurement");
   est_load_a: assert property (r.st == ST_DIV && r.div_i == 6'h20
      |=> r.st == ST_LOCK && tuning_word == r.base)
      else $error("estimate not loaded on entering lock");
   no_est_a: assert property (r.st == ST_IDLE && r.ctrl[`DIGITAL_LOOP_CORE_C_RUN] &&
      !r.ctrl[`DIGITAL_LOOP_CORE_C_EST] && !(r.aw_got && r.w_got && !r.bvalid)
      |=> r.st == ST_LOCK)
      else $error("loop did not start without estimator");
   loop_hold_a: assert property (r.st == ST_LOCK && !pfd_done && !hold_req
      && r.ctrl[`DIGITAL_LOOP_CORE_C_RUN] |=> $stable(tuning_word))
      else $error("tuning word moved without an error word");
   man_hold_a: assert property (r.st == ST_LOCK && r.ctrl[`DIGITAL_LOOP_CORE_C_RUN] &&
      !r.ctrl[`DIGITAL_LOOP_CORE_C_HOLDA] && r.hold_s2 |=> r.st == ST_HOLD ##1 holdover_pin_out)
      else $error("forced holdover not taken");
   sel_drive_a: assert property (r.ctrl[`DIGITAL_LOOP_CORE_C_SWA] [*2]
      |-> !reference_choice_pin_oe_n)
      else $error("reference pin not driven in automatic mode");
   sel_follow_a: assert property (!r.ctrl[`DIGITAL_LOOP_CORE_C_SWA] && r.sel_s2
      |=> reference_choice_pin_out)
      else $error("manual reference choice not followed");
   irq_level_a: assert property ((r.istat & r.ien) == 4'h0 && ev == 4'h0
      && !(r.aw_got && r.w_got && !r.bvalid) |=> !irq)
      else $error("interrupt raised with no enabled event");

   est_flow_c: cover property (r.st == ST_DIV ##1 r.st == ST_LOCK);
   hold_in_c: cover property (r.st == ST_LOCK ##1 r.st == ST_HOLD);
   auto_sw_c: cover property (r.ctrl[`DIGITAL_LOOP_CORE_C_SWA] && sw_ev);

endmodule
`default_nettype wire

// ---- rtl/digital_loop_core_defs.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef DIGITAL_LOOP_CORE_DEFS_SVH
`define DIGITAL_LOOP_CORE_DEFS_SVH

`define DIGITAL_LOOP_CORE_A_CTRL    8'h00
`define DIGITAL_LOOP_CORE_A_RDIV    8'h04
`define DIGITAL_LOOP_CORE_A_SDIV    8'h08
`define DIGITAL_LOOP_CORE_A_GAIN    8'h0c
`define DIGITAL_LOOP_CORE_A_FTWI    8'h10
`define DIGITAL_LOOP_CORE_A_STAT    8'h14
`define DIGITAL_LOOP_CORE_A_FTW     8'h18
`define DIGITAL_LOOP_CORE_A_ISTAT   8'h1c
`define DIGITAL_LOOP_CORE_A_ICLR    8'h20
`define DIGITAL_LOOP_CORE_A_IEN     8'h24

`define DIGITAL_LOOP_CORE_C_EST     0
`define DIGITAL_LOOP_CORE_C_HOLDA   1
`define DIGITAL_LOOP_CORE_C_SWA     2
`define DIGITAL_LOOP_CORE_C_RUN     3
`define DIGITAL_LOOP_CORE_C_RESTART 4

`define DIGITAL_LOOP_CORE_I_LOCK    0
`define DIGITAL_LOOP_CORE_I_HOLD    1
`define DIGITAL_LOOP_CORE_I_SW      2
`define DIGITAL_LOOP_CORE_I_LOSS    3

`define DIGITAL_LOOP_CORE_RST_GAIN  8'h44
`define DIGITAL_LOOP_CORE_RST_FTWI  32'h1000_0000
`define DIGITAL_LOOP_CORE_FTW_SAT   32'h7fff_ffff

`define DIGITAL_LOOP_CORE_CLK_NS    4
`define DIGITAL_LOOP_CORE_LOSS_NS   10000
`define DIGITAL_LOOP_CORE_LOSS_CYC  ((`DIGITAL_LOOP_CORE_LOSS_NS + `DIGITAL_LOOP_CORE_CLK_NS - 1) / `DIGITAL_LOOP_CORE_CLK_NS)
`define DIGITAL_LOOP_CORE_AVG_SH    4

`define DIGITAL_LOOP_CORE_OKAY      2'h0
`define DIGITAL_LOOP_CORE_SLVERR    2'h2

`endif

// ---- rtl/digital_loop_core_pkg.sv ----
// Types shared by the digital loop core and its dividers
package digital_loop_core_pkg;

   typedef enum logic [2:0] {ST_IDLE, ST_MEAS, ST_DIV, ST_LOCK, ST_HOLD}
      digital_loop_core_mode_t;

   typedef struct packed {
      digital_loop_core_mode_t  st;
      logic [3:0]   ctrl;
      logic [15:0]  rdiv;
      logic [15:0]  sdiv;
      logic [7:0]   gain;
      logic [31:0]  ftwi;
      logic [31:0]  base;
      logic [31:0]  ftw;
      logic [31:0]  integ;
      logic [31:0]  avg;
      logic [31:0]  meas_cnt;
      logic [31:0]  div_q;
      logic [32:0]  div_rem;
      logic [5:0]   div_i;
      logic         div_ovf;
      logic         meas_arm;
      logic [19:0]  pfd_cnt;
      logic         pfd_up;
      logic         pfd_dn;
      logic [11:0]  loss_a;
      logic [11:0]  loss_b;
      logic         sel;
      logic         hold_out;
      logic         sel_oe_n;
      logic         hold_oe_n;
      logic         hold_s1;
      logic         hold_s2;
      logic         sel_s1;
      logic         sel_s2;
      logic [3:0]   istat;
      logic [3:0]   ien;
      logic         irq;
      logic         awready;
      logic         wready;
      logic         bvalid;
      logic         arready;
      logic         rvalid;
      logic         aw_got;
      logic         w_got;
      logic [1:0]   bresp;
      logic [1:0]   rresp;
      logic [7:0]   awaddr;
      logic [31:0]  wdata;
      logic [3:0]   wstrb;
      logic [31:0]  rdata;
   } digital_loop_core_core_t;

   typedef struct packed {
      logic         s1;
      logic         s2;
      logic         s3;
      logic [15:0]  cnt;
      logic         tick;
      logic         div_tick;
   } digital_loop_core_div_t;

endpackage

// ---- rtl/digital_loop_core_div_if.sv ----
// Link between the loop core and one edge divider
`timescale 1ns/10ps
`default_nettype none
interface digital_loop_core_div_if;
   logic [15:0] ratio;
   logic        tick;
   logic        div_tick;
   modport core (output ratio, input tick, input div_tick);
   modport div (input ratio, output tick, output div_tick);
endinterface
`default_nettype wire

// ---- rtl/digital_loop_core_divider.sv ----
// Synchronising integer edge divider
`timescale 1ns/10ps
`default_nettype none
module digital_loop_core_divider
   import digital_loop_core_pkg::*;
(
   input  wire logic   clk,
   input  wire logic   nrst,
   input  wire logic   pin,
   digital_loop_core_div_if.div    port
);

   digital_loop_core_div_t r;
   digital_loop_core_div_t next_r;
   logic       rise;

   assign rise = r.s2 & ~r.s3;

   always_comb begin
      next_r = r;
      next_r.s1 = pin;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      next_r.tick = rise;
      next_r.div_tick = 1'b0;
      if (rise) begin
         if (r.cnt >= port.ratio) begin
            next_r.cnt = 16'h0000;
            next_r.div_tick = 1'b1;
         end else begin
            next_r.cnt = r.cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign port.tick = r.tick;
   assign port.div_tick = r.div_tick;

   div_ratio_a: assert property (@(posedge clk) disable iff (!nrst)
      rise && r.cnt == port.ratio |=> port.div_tick)
      else $error("divider missed its terminal edge");
   div_early_a: assert property (@(posedge clk) disable iff (!nrst)
      rise && r.cnt < port.ratio |=> !port.div_tick)
      else $error("divider fired before its modulus");

endmodule
`default_nettype wire

// ---- bench/digital_loop_core_partner.sv ----
// Reference and feedback clock sources facing the loop core
`timescale 1ns/10ps
`default_nettype none
module digital_loop_core_partner (
   input  wire logic [7:0] per_a,
   input  wire logic       run_a,
   output logic            ref_a,
   output logic            ref_b,
   output logic            fb
);
   initial begin
      ref_a = 1'b0;
      ref_b = 1'b0;
      fb = 1'b0;
   end
   // A stopped source rests low
   always #(per_a * 2) ref_a = run_a & ~ref_a;
   always #80 ref_b = ~ref_b;
   always #52 fb = ~fb;
endmodule
`default_nettype wire

// ---- bench/test_digital_pll_core_control.sv ----
// Self-checking bench for the digital loop core
`timescale 1ns/10ps
`default_nettype none
`include "digital_loop_core_defs.svh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
   $display("MISMATCH %s exp %h seen %h", n, e, g); n_fail++; end end
module test_digital_pll_core_control
   import digital_loop_core_pkg::*;
;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, per_a = 8'h20;
   logic [31:0] wdata = 32'h0, tw, rdata, rv, q;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid, irq, run_a = 1;
   logic [1:0]  bresp, rresp, rs;
   logic        ref_a, ref_b, fb, sel_o, sel_oe_n, hold_o, hold_oe_n;
   logic        hold_drv = 1'b0;
   int          n_fail = 0, n_tests = 0, p, s, r;
   logic [31:0] m [int];
   wire         sel_w = sel_oe_n ? 1'b0 : sel_o;
   wire         hold_w = hold_oe_n ? hold_drv : hold_o;
   wire [2:0]   ev = {sel_o, irq, tw != `DIGITAL_LOOP_CORE_RST_FTWI};
   always #2 clk = ~clk;
   digital_loop_core_core dut_u (.clk(clk), .nrst(nrst), .first_reference_input(ref_a),
      .second_reference_input(ref_b), .feedback_input(fb), .tuning_word(tw),
      .reference_choice_pin_in(sel_w), .reference_choice_pin_out(sel_o),
      .reference_choice_pin_oe_n(sel_oe_n), .holdover_pin_in(hold_w),
      .holdover_pin_out(hold_o), .holdover_pin_oe_n(hold_oe_n), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   digital_loop_core_partner partner_u (.per_a(per_a), .run_a(run_a), .ref_a(ref_a),
      .ref_b(ref_b), .fb(fb));
   task automatic report_and_stop();
      $display("Counts: %0d compared, %0d mismatched", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic tmo();
      n_fail++;
      $display("Wait ran out");
      report_and_stop();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int i;
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            rs = bresp;
            break;
         end
      end
      bready <= 1'b0;
      if (i == 50) tmo();
      if (a inside {8'h04, 8'h08, 8'h24}) m[a] = v;
   endtask
   task automatic rd(input logic [7:0] a);
      int i;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rv = rdata;
      rs = rresp;
      rready <= 1'b0;
      if (i == 50) tmo();
   endtask
   task automatic chk_regs();
      foreach (m[k]) begin
         rd(k[7:0]);
         `CHK("register", m[k], rv)
      end
   endtask
   task automatic wait_ev(input int k, input int lim);
      int i;
      for (i = 0; i < lim && ev[k] !== 1'b1; i++)
         @(posedge clk);
      if (i == lim) tmo();
   endtask
   initial begin
      void'($urandom(28124));
      m[`DIGITAL_LOOP_CORE_A_GAIN] = 32'(`DIGITAL_LOOP_CORE_RST_GAIN);
      m[`DIGITAL_LOOP_CORE_A_FTWI] = `DIGITAL_LOOP_CORE_RST_FTWI;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      chk_regs();
      `CHK("tuning", `DIGITAL_LOOP_CORE_RST_FTWI, tw)
      `CHK("pins oe", 2'b11, {sel_oe_n, hold_oe_n})
      rd(8'h3c);
      `CHK("unmapped", {`DIGITAL_LOOP_CORE_SLVERR, 32'h0}, {rs, rv})
      wr(8'h3c, 32'h0);
      `CHK("unmapped write", `DIGITAL_LOOP_CORE_SLVERR, rs)
      $display("Reset and register test done");
      p = 30 + $urandom % 18;
      r = 1 + $urandom % 2;
      s = 1 + $urandom % 3;
      per_a <= 8'(p);
      q = 32'((64'(s) << 32) / (p * r));
      wr(`DIGITAL_LOOP_CORE_A_RDIV, 32'(r - 1));
      wr(`DIGITAL_LOOP_CORE_A_SDIV, 32'(s - 1));
      wr(`DIGITAL_LOOP_CORE_A_IEN, 32'h1);
      wr(`DIGITAL_LOOP_CORE_A_CTRL, 32'h9);
      wait_ev(0, 3000);
      `CHK("estimate", q, tw)
      wait_ev(1, 20);
      rd(`DIGITAL_LOOP_CORE_A_STAT);
      `CHK("lock state", 3'h3, rv[2:0])
      wr(`DIGITAL_LOOP_CORE_A_ICLR, 32'h1);
      repeat (2) @(posedge clk);
      `CHK("irq cleared", 1'b0, irq)
      $display("Estimator test done");
      hold_drv <= 1'b1;
      repeat (10) @(posedge clk);
      rd(`DIGITAL_LOOP_CORE_A_STAT);
      `CHK("hold state", 4'hc, {rv[4], rv[2:0]})
      `CHK("hold pin", 1'b1, hold_o)
      rd(`DIGITAL_LOOP_CORE_A_ISTAT);
      `CHK("hold event", 1'b1, rv[1])
      hold_drv <= 1'b0;
      $display("Manual holdover test done");
      wr(`DIGITAL_LOOP_CORE_A_CTRL, 32'hf);
      repeat (2) @(posedge clk);
      `CHK("auto pins", 3'b000, {sel_oe_n, hold_oe_n, sel_o})
      run_a <= 1'b0;
      wait_ev(2, 4000);
      rd(`DIGITAL_LOOP_CORE_A_ISTAT);
      `CHK("switch events", 2'b11, rv[3:2])
      chk_regs();
      $display("Automatic switchover test done");
      wr(`DIGITAL_LOOP_CORE_A_CTRL, 32'h18);
      rd(`DIGITAL_LOOP_CORE_A_STAT);
      `CHK("no estimator", 3'h3, rv[2:0])
      $display("Phase loop only test done");
      report_and_stop();
   end
endmodule
`default_nettype wire
